// ==== rtl/evru_defines.vh ====
// Constants for the exception vector and reset unit.
// Assumes inclusion by evru_core.v only.
`ifndef EVRU_DEFINES_VH
`define EVRU_DEFINES_VH
`define EVRU_VEC_RESET_SSP 8'h00
`define EVRU_VEC_BUS_ERR 8'h02
`define EVRU_VEC_ADDR_ERR 8'h03
`define EVRU_VEC_ILLEGAL 8'h04
`define EVRU_VEC_DIV_ZERO 8'h05
`define EVRU_VEC_BOUNDS 8'h06
`define EVRU_VEC_OVF_TRAP 8'h07
`define EVRU_VEC_PRIV 8'h08
`define EVRU_VEC_TRACE 8'h09
`define EVRU_VEC_LINE_A 8'h0a
`define EVRU_VEC_LINE_F 8'h0b
`define EVRU_VEC_UNINIT 8'h0f
`define EVRU_VEC_SPURIOUS 8'h18
`define EVRU_VEC_TRAP_BASE 8'h20
`define EVRU_TABLE_BASE 24'h000000
`define EVRU_TABLE_LAST 24'h0003ff
`define EVRU_IPL_RESET 3'h7
`define EVRU_SRC_INTERNAL 2'h0
`define EVRU_SRC_TRAP 2'h1
`define EVRU_SRC_IACK 2'h2
`define EVRU_SRC_AUTO 2'h3
`define EVRU_RSTO_NS 124
`endif

// ==== rtl/evru_core.v ====
// Exception vector address generation and reset sequencing.
// Assumes a word-wide memory reader that answers rd_req with rd_ack.
`timescale 1ns/10ps
`include "evru_defines.vh"
module evru_core #(
  parameter RSTO_NS = `EVRU_RSTO_NS,
  parameter CLK_PERIOD_NS = 5
) (
  input wire core_clk,
  input wire rst_n,
  input wire exc_req,
  input wire [1:0] exc_src,
  input wire [7:0] exc_vec_num,
  input wire [3:0] trap_num,
  input wire [2:0] iack_level,
  input wire iack_berr,
  input wire [15:0] bus_data,
  output wire exc_busy,
  output reg exc_done_ff,
  output reg [7:0] vec_num_ff,
  output reg [23:0] addr_ff,
  output reg rd_req_ff,
  input wire rd_ack,
  output reg supervisor_program_space_ff,
  output reg supervisor_data_space_ff,
  output reg iack_cycle_ff,
  output reg [31:0] vec_value_ff,
  output reg [31:0] supervisor_stack_pointer_ff,
  output reg [31:0] pc_ff,
  output reg pc_valid_ff,
  output reg supervisor_ff,
  output reg trace_ff,
  output reg [2:0] ipl_mask_ff,
  input wire reset_instr,
  output reg reset_out_ff,
  output wire reset_out_done
);
  localparam ST_RESET_SSP_HI = 3'h0;
  localparam ST_RESET_SSP_LO = 3'h1;
  localparam ST_RESET_PC_HI = 3'h2;
  localparam ST_RESET_PC_LO = 3'h3;
  localparam ST_IDLE = 3'h4;
  localparam ST_IACK = 3'h5;
  localparam ST_VEC_HI = 3'h6;
  localparam ST_VEC_LO = 3'h7;
  // Least pulse time rounds up to whole cycles
  localparam RSTO_CYC = (RSTO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam [7:0] RSTO_CNT = RSTO_CYC[7:0];

  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg [7:0] rsto_cnt_ff;
  reg [2:0] lvl_ff;
  wire [31:0] offset;
  reg [7:0] nxt_vec;

  // Start and answer strobes, named once for the next-state, word and reset out processes below
  wire word_taken;
  wire take_iack;
  wire take_vec;
  wire rsto_start;

  // Zero-filled long offset doubles as absolute address
  assign offset = {22'h000000, vec_num_ff, 2'h0};
  assign exc_busy = (state_ff != ST_IDLE);
  assign reset_out_done = reset_out_ff && (rsto_cnt_ff == 8'h01);
  // An answer only counts while a read is asked for
  assign word_taken = rd_req_ff && rd_ack;
  assign take_iack = exc_req && (exc_src == `EVRU_SRC_IACK);
  assign take_vec = exc_req && (exc_src != `EVRU_SRC_IACK);
  assign rsto_start = reset_instr && supervisor_ff && !reset_out_ff;

  always @* begin
    nxt_vec = exc_vec_num;
    case (exc_src)
      `EVRU_SRC_TRAP: begin
        nxt_vec = `EVRU_VEC_TRAP_BASE + {4'h0, trap_num};
      end
      `EVRU_SRC_AUTO: begin
        // Level 0 never reaches here; it would alias spurious
        nxt_vec = `EVRU_VEC_SPURIOUS + {5'h00, iack_level};
      end
      default: begin
        nxt_vec = exc_vec_num;
      end
    endcase
  end

  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_RESET_SSP_HI: begin
        if (word_taken) nxt_state = ST_RESET_SSP_LO;
      end
      ST_RESET_SSP_LO: begin
        if (word_taken) nxt_state = ST_RESET_PC_HI;
      end
      ST_RESET_PC_HI: begin
        if (word_taken) nxt_state = ST_RESET_PC_LO;
      end
      ST_RESET_PC_LO: begin
        if (word_taken) nxt_state = ST_IDLE;
      end
      ST_IDLE: begin
        if (take_iack) begin
          nxt_state = ST_IACK;
        end else if (take_vec) begin
          nxt_state = ST_VEC_HI;
        end
      end
      ST_IACK: begin
        // Bus error ends the acknowledge as well as an answer
        if (word_taken || iack_berr) nxt_state = ST_VEC_HI;
      end
      ST_VEC_HI: begin
        if (word_taken) nxt_state = ST_VEC_LO;
      end
      ST_VEC_LO: begin
        if (word_taken) nxt_state = ST_IDLE;
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  // Reset wins over everything; no stacking happens here at all
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_RESET_SSP_HI;
      vec_num_ff <= 8'h00;
      addr_ff <= 24'h000000;
      rd_req_ff <= 1'b0;
      supervisor_program_space_ff <= 1'b0;
      supervisor_data_space_ff <= 1'b0;
      iack_cycle_ff <= 1'b0;
      exc_done_ff <= 1'b0;
      lvl_ff <= 3'h0;
    end else begin
      state_ff <= nxt_state;
      exc_done_ff <= 1'b0;
      rd_req_ff <= 1'b0;
      iack_cycle_ff <= 1'b0;
      supervisor_program_space_ff <= 1'b0;
      supervisor_data_space_ff <= 1'b0;
      case (state_ff)
        ST_RESET_SSP_HI, ST_RESET_SSP_LO, ST_RESET_PC_HI,
        ST_RESET_PC_LO: begin
          // Reset vector is four words in program space
          rd_req_ff <= ~rd_ack;
          supervisor_program_space_ff <= ~rd_ack;
          // Next word of the entry; idle code wraps back to zero
          addr_ff <= `EVRU_TABLE_BASE
            + {21'h000000, nxt_state[1:0], 1'b0};
        end
        ST_IDLE: begin
          if (exc_req) begin
            lvl_ff <= iack_level;
            vec_num_ff <= nxt_vec;
            if (exc_src == `EVRU_SRC_IACK) begin
              iack_cycle_ff <= 1'b1;
              rd_req_ff <= 1'b1;
              addr_ff <= {20'h00000, iack_level, 1'b1};
            end else begin
              rd_req_ff <= 1'b1;
              supervisor_data_space_ff <= 1'b1;
              addr_ff <= {14'h0000, nxt_vec, 2'h0};
            end
          end
        end
        ST_IACK: begin
          iack_cycle_ff <= ~(rd_ack | iack_berr);
          rd_req_ff <= 1'b1;
          if (iack_berr) begin
            vec_num_ff <= `EVRU_VEC_SPURIOUS;
            addr_ff <= {14'h0000, `EVRU_VEC_SPURIOUS, 2'h0};
            supervisor_data_space_ff <= 1'b1;
          end else if (rd_ack) begin
            vec_num_ff <= bus_data[7:0];
            addr_ff <= {14'h0000, bus_data[7:0], 2'h0};
            supervisor_data_space_ff <= 1'b1;
          end else begin
            addr_ff <= {20'h00000, lvl_ff, 1'b1};
          end
        end
        ST_VEC_HI: begin
          rd_req_ff <= 1'b1;
          supervisor_data_space_ff <= 1'b1;
          addr_ff <= offset[23:0];
          if (rd_ack) begin
            addr_ff <= offset[23:0] + 24'h000002;
          end
        end
        ST_VEC_LO: begin
          rd_req_ff <= ~rd_ack;
          supervisor_data_space_ff <= ~rd_ack;
          addr_ff <= offset[23:0] + 24'h000002;
          if (rd_ack) begin
            exc_done_ff <= 1'b1;
          end
        end
        default: rd_req_ff <= 1'b0;
      endcase
    end
  end

  // Status bits; interrupts also set the mask to their level
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      supervisor_ff <= 1'b1;
      trace_ff <= 1'b0;
      ipl_mask_ff <= `EVRU_IPL_RESET;
    end else if (state_ff == ST_IDLE && exc_req) begin
      supervisor_ff <= 1'b1;
      trace_ff <= 1'b0;
      if (exc_src == `EVRU_SRC_IACK || exc_src == `EVRU_SRC_AUTO) begin
        ipl_mask_ff <= iack_level;
      end
    end
  end

  // Words land only on an answered read of the matching state
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      vec_value_ff <= 32'h00000000;
      supervisor_stack_pointer_ff <= 32'h00000000;
      pc_ff <= 32'h00000000;
      pc_valid_ff <= 1'b0;
    end else if (word_taken) begin
      case (state_ff)
        ST_RESET_SSP_HI: begin
          supervisor_stack_pointer_ff[31:16] <= bus_data;
        end
        ST_RESET_SSP_LO: begin
          supervisor_stack_pointer_ff[15:0] <= bus_data;
        end
        ST_RESET_PC_HI: begin
          pc_ff[31:16] <= bus_data;
        end
        ST_RESET_PC_LO: begin
          pc_ff[15:0] <= bus_data;
          pc_valid_ff <= 1'b1;
        end
        ST_VEC_HI: begin
          vec_value_ff[31:16] <= bus_data;
        end
        ST_VEC_LO: begin
          // Handler address goes straight on, no extra cycle
          vec_value_ff[15:0] <= bus_data;
          pc_ff <= {vec_value_ff[31:16], bus_data};
        end
        default: begin
          pc_valid_ff <= pc_valid_ff;
        end
      endcase
    end
  end

  // Reset out pulse; no exception, processing carries on
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reset_out_ff <= 1'b0;
      rsto_cnt_ff <= 8'h00;
    end else if (rsto_start) begin
      reset_out_ff <= 1'b1;
      rsto_cnt_ff <= RSTO_CNT;
    end else if (reset_out_ff) begin
      // A new request while pulsing is ignored, not queued
      rsto_cnt_ff <= rsto_cnt_ff - 8'h01;
      if (rsto_cnt_ff == 8'h01) begin
        reset_out_ff <= 1'b0;
      end
    end
  end
endmodule // evru_core

// ==== bench/evru_mem_model.sv ====
// Memory holding the vector table, plus the interrupting peripheral.
// Assumes evru_core read handshake; answers at once or every other cycle.
`timescale 1ns/10ps
module evru_mem_model (
  input wire core_clk,
  input wire rd_req_ff,
  input wire iack_cycle_ff,
  input wire slow,
  input wire [7:0] mvec,
  input wire [23:0] addr_ff,
  output wire rd_ack,
  output wire [15:0] bus_data
);
  reg ph_ff = 1'h0;
  reg [15:0] last_ff = 16'h0;
  // Entry number in the high byte, its complement in the low byte, bit 0 marks the low word
  wire [15:0] word = {addr_ff[9:2], ~addr_ff[9:2]} ^ {15'h0, addr_ff[1]};
  // Upper byte is junk; the bench never hands a reserved vector
  wire [15:0] nxt_data = iack_cycle_ff ? {8'hc3, mvec} : word;
  assign rd_ack = rd_req_ff & (ph_ff | ~slow);
  // Released bus shows no stale copy
  assign bus_data = rd_ack ? nxt_data : ~last_ff;
  always @(posedge core_clk) begin
    ph_ff <= ~ph_ff;
    if (rd_ack)
      last_ff <= nxt_data;
  end
endmodule // evru_mem_model

// ==== bench/evru_chk.sv ====
// Port-level assertions for evru_core.
// Assumes bind to evru_core; one clock, async low reset.
`timescale 1ns/10ps
module evru_chk (
  input wire core_clk, rst_n, exc_req, exc_busy, exc_done_ff, rd_req_ff,
  input wire rd_ack, iack_cycle_ff, iack_berr, reset_instr, reset_out_ff,
  input wire supervisor_program_space_ff, supervisor_data_space_ff,
  input wire supervisor_ff, trace_ff,
  input wire reset_out_done,
  input wire [1:0] exc_src,
  input wire [2:0] iack_level, ipl_mask_ff,
  input wire [3:0] trap_num,
  input wire [7:0] exc_vec_num, vec_num_ff,
  input wire [15:0] bus_data,
  input wire [23:0] addr_ff,
  input wire [31:0] pc_ff, vec_value_ff
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire ack = rd_req_ff & rd_ack;
  wire vec_rd = ack & supervisor_data_space_ff & ~iack_cycle_ff;
  reg src2_ff;
  reg [2:0] lvl_ff;
  reg [7:0] exp_ff;
  // Reset fetch has no expected number, so it starts disarmed
  always @(posedge core_clk or negedge rst_n)
    if (!rst_n) begin
      src2_ff <= 1'h1;
    end else if (exc_req && !exc_busy) begin
      src2_ff <= exc_src == 2'h2;
      lvl_ff <= iack_level;
      exp_ff <= !exc_src[0] ? exc_vec_num :
        exc_src[1] ? 8'h18 + iack_level : {4'h2, trap_num};
    end
  vec_addr_a:
    assert property (vec_rd |-> addr_ff[23:2] == {14'h0, vec_num_ff})
    else $error("vector address not number times four");
  reset_fetch_a:
    assert property (ack && supervisor_program_space_ff
      |-> addr_ff[23:3] == 21'h0 && !supervisor_data_space_ff)
    else $error("program space read outside reset entry");
  req_hold_a:
    assert property (rd_req_ff && !rd_ack |=> rd_req_ff && $stable(addr_ff))
    else $error("read request moved before answer");
  iack_addr_a:
    assert property (ack && iack_cycle_ff |-> addr_ff == {20'h0, lvl_ff, 1'h1})
    else $error("acknowledge address lacks level");
  iack_vec_a:
    assert property (ack && iack_cycle_ff |=> vec_num_ff ==
      ($past(iack_berr) ? 8'h18 : $past(bus_data[7:0])))
    else $error("acknowledged vector not taken");
  done_vec_a:
    assert property (exc_done_ff && !src2_ff |-> vec_num_ff == exp_ff)
    else $error("internal vector number wrong");
  low_word_a:
    assert property (vec_rd && addr_ff[1] |=> exc_done_ff
      && pc_ff[15:0] == $past(bus_data))
    else $error("handler low word not loaded");
  rst_entry_a:
    assert property ($rose(rst_n) |-> supervisor_ff && !trace_ff
      && ipl_mask_ff == 3'h7 ##1 rd_req_ff && addr_ff == 24'h0)
    else $error("reset entry state wrong");
  rsto_a:
    assert property (reset_instr && supervisor_ff && !reset_out_ff
      && !exc_busy |=> (reset_out_ff && !exc_busy)[*8])
    else $error("reset output pulse wrong");
  rsto_end_a:
    assert property (reset_out_done |-> reset_out_ff ##1 !reset_out_ff)
    else $error("reset output end marker wrong");
  vec_long_a:
    assert property (exc_done_ff |-> vec_value_ff == pc_ff)
    else $error("fetched vector and program counter differ");
  c_berr: cover property (ack && iack_cycle_ff && iack_berr);
  c_trap: cover property (exc_done_ff && vec_num_ff[5]);
  c_rsto: cover property ($fell(reset_out_ff));
endmodule // evru_chk

bind evru_core evru_chk u_chk (.*);

// ==== bench/tb_evru_core.sv ====
// Self-checking bench for evru_core.
// Assumes evru_mem_model answers reads and evru_chk is bound.
`timescale 1ns/10ps
module tb_evru_core;
  reg core_clk = 1'h0, rst_n = 1'h0, exc_req = 1'h0, iack_berr = 1'h0;
  reg reset_instr = 1'h0, slow = 1'h0;
  reg [1:0] exc_src = 2'h0;
  reg [2:0] iack_level = 3'h0;
  reg [3:0] trap_num = 4'h0;
  reg [7:0] exc_vec_num = 8'h0, mvec = 8'h40;
  wire exc_busy, exc_done_ff, rd_req_ff, rd_ack, iack_cycle_ff, reset_out_ff;
  wire supervisor_program_space_ff, supervisor_data_space_ff;
  wire supervisor_ff, trace_ff, pc_valid_ff;
  wire [2:0] ipl_mask_ff;
  wire [7:0] vec_num_ff;
  wire [15:0] bus_data;
  wire [23:0] addr_ff;
  wire [31:0] pc_ff, supervisor_stack_pointer_ff;
  integer mismatches = 0, check_count = 0, cyc = 0, n, i;
  evru_core u_dut (.vec_value_ff(), .reset_out_done(), .*);
  evru_mem_model u_mem (.*);
  always #2.5 core_clk = ~core_clk;
  task test_done;
    begin
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  // Ceiling well above the few hundred cycles the tests need
  always @(posedge core_clk) begin
    cyc = cyc + 1;
    if (cyc == 8000) begin
      mismatches = mismatches + 1;
      test_done;
    end
  end
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("wrong value %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  function [15:0] wd(input [9:0] a);
    wd = {a[9:2], ~a[9:2]} ^ {15'h0, a[1]};
  endfunction
  function [31:0] lw(input [7:0] v);
    lw = {wd({v, 2'h0}), wd({v, 2'h2})};
  endfunction
  task tick;
    begin
      @(posedge core_clk);
      #1;
    end
  endtask
  task start(input [1:0] s, input [7:0] v);
    begin
      exc_req = 1'h1;
      exc_src = s;
      exc_vec_num = v;
      trap_num = v[3:0];
      iack_level = v[2:0];
      tick;
      exc_req = 1'h0;
    end
  endtask
  task exc(input [1:0] s, input [7:0] v, input [7:0] ev);
    begin
      start(s, v);
      for (n = 0; exc_done_ff !== 1'h1 && n < 99; n = n + 1)
        tick;
      chk("vector", vec_num_ff, ev);
      chk("pc", pc_ff, lw(ev));
      tick;
    end
  endtask
  task do_reset;
    begin
      rst_n = 1'h0;
      repeat (5) tick;
      rst_n = 1'h1;
      for (n = 0; exc_busy !== 1'h0 && n < 99; n = n + 1)
        tick;
      chk("ssp", supervisor_stack_pointer_ff, lw(8'h0));
      chk("pc", pc_ff, lw(8'h1));
      chk("status", {supervisor_ff, trace_ff, ipl_mask_ff, pc_valid_ff},
        6'h2f);
    end
  endtask
  initial begin
    do_reset;
    for (i = 2; i < 16; i = i + 1)
      if (i < 12 || i == 15)
        exc(2'h0, i[7:0], i[7:0]);
    slow = 1'h1;
    for (i = 0; i < 16; i = i + 1)
      exc(2'h1, i[7:0], 8'h20 + i[7:0]);
    slow = 1'h0;
    for (i = 1; i < 8; i = i + 1)
      exc(2'h3, i[7:0], 8'h18 + i[7:0]);
    mvec = 8'hff;
    exc(2'h2, 8'h3, 8'hff);
    mvec = 8'h40;
    exc(2'h2, 8'h5, 8'h40);
    chk("mask", ipl_mask_ff, 3'h5);
    iack_berr = 1'h1;
    exc(2'h2, 8'h2, 8'h18);
    iack_berr = 1'h0;
    slow = 1'h1;
    start(2'h2, 8'h6);
    tick;
    do_reset;
    slow = 1'h0;
    reset_instr = 1'h1;
    tick;
    reset_instr = 1'h0;
    for (n = 0; reset_out_ff === 1'h1 && n < 99; n = n + 1)
      tick;
    chk("rsto", n, (124 + 4) / 5);
    chk("busy", {exc_busy, pc_valid_ff}, 2'h1);
    exc(2'h0, 8'h7, 8'h7);
    test_done;
  end
endmodule // tb_evru_core
